// file: include/bobx_pkg.sv
/*
 Package for the byte-op and branch execution block: opcode layout,
 field positions, reset constants and the carrier struct shared by the files.
 Assumes a 14-bit instruction word and an 8-bit data path.
*/
package bobx_pkg;
   localparam int INSN_W   = 14;
   localparam int DATA_W   = 8;
   localparam int FADDR_W  = 7;
   localparam int PC_W     = 15;
   localparam int JUMP_W   = 11;
   localparam int LATCH_W  = 7;

   // Opcode fields
   localparam logic [5:0] OPC_DEC_SKIP = 6'h0B;
   localparam logic [5:0] OPC_INC_FILE = 6'h0A;
   localparam logic [5:0] OPC_INC_SKIP = 6'h0F;
   localparam logic [5:0] OPC_OR_LIT   = 6'h38;
   localparam logic [2:0] OPC_JUMP     = 3'h5;
   localparam int         OP6_HI       = 13;
   localparam int         OP6_LO       = 8;
   localparam int         OP3_LO       = 11;
   localparam int         DEST_BIT     = 7;
   localparam int         LATCH_HI     = 6;
   localparam int         LATCH_LO     = 3;
   localparam logic       DEST_ACC     = 1'b0;
   localparam logic       DEST_FILE    = 1'b1;

   localparam logic [DATA_W-1:0]  ACC_RST   = 8'h00;
   localparam logic [PC_W-1:0]    PC_RST    = 15'h0000;
   localparam logic [DATA_W-1:0]  ONE       = 8'h01;
   localparam logic [DATA_W-1:0]  ZERO      = 8'h00;

   typedef enum logic [2:0] {
      BOBX_OP_NONE, BOBX_OP_DEC_SKIP, BOBX_OP_INC_FILE,
      BOBX_OP_INC_SKIP, BOBX_OP_OR_LIT, BOBX_OP_JUMP
   } bobx_op_t;

   typedef struct packed {
      logic [DATA_W-1:0]  data;
      logic [FADDR_W-1:0] addr;
      logic               wr;
   } bobx_file_wr_t;
endpackage

// file: rtl/bobx_decode.sv
/*
 Instruction decoder: classifies a 14-bit word into one of the executed ops.
 Assumes the word is stable for the cycle in which it is presented.
*/
`timescale 1ns/1ps
module bobx_decode (
   input  wire logic [bobx_pkg::INSN_W-1:0] insn,
   output bobx_pkg::bobx_op_t               op
);
   wire logic [5:0] op6 = insn[bobx_pkg::OP6_HI:bobx_pkg::OP6_LO];
   wire logic [2:0] op3 = insn[bobx_pkg::OP6_HI:bobx_pkg::OP3_LO];

   assign op = (op3 == bobx_pkg::OPC_JUMP)     ? bobx_pkg::BOBX_OP_JUMP :
               (op6 == bobx_pkg::OPC_DEC_SKIP) ? bobx_pkg::BOBX_OP_DEC_SKIP :
               (op6 == bobx_pkg::OPC_INC_FILE) ? bobx_pkg::BOBX_OP_INC_FILE :
               (op6 == bobx_pkg::OPC_INC_SKIP) ? bobx_pkg::BOBX_OP_INC_SKIP :
               (op6 == bobx_pkg::OPC_OR_LIT)   ? bobx_pkg::BOBX_OP_OR_LIT :
                                                 bobx_pkg::BOBX_OP_NONE;
endmodule

// file: rtl/bobx_exec.sv
/*
 Execution unit for decrement/increment of a file register with optional
 skip on zero, OR of the accumulator with a literal, and the absolute jump.
 Assumes the file register data for the addressed location arrives
 combinationally on fileRdData in the cycle insnValid is high, and that
 the caller feeds the next instruction word after each accepted cycle.
*/
`timescale 1ns/1ps
module bobx_exec (
   input  wire logic                          clk_sys,
   input  wire logic                          rst,
   input  wire logic                          insnValid,
   input  wire logic [bobx_pkg::INSN_W-1:0]   insnWord,
   input  wire logic [bobx_pkg::DATA_W-1:0]   fileRdData,
   input  wire logic [bobx_pkg::LATCH_W-1:0]  latchHigh,
   output logic      [bobx_pkg::FADDR_W-1:0]  fileRdAddr,
   output bobx_pkg::bobx_file_wr_t            fileWr,
   output logic      [bobx_pkg::DATA_W-1:0]   accOut,
   output logic                               zeroFlag,
   output logic      [bobx_pkg::PC_W-1:0]     pcOut,
   output logic                               nopCycle,
   output logic                               busy
);
   bobx_pkg::bobx_op_t op;

   bobx_decode u_decode (
      .insn (insnWord),
      .op   (op)
   );

   logic [bobx_pkg::DATA_W-1:0]  acc_ff;
   logic                         zero_ff;
   logic [bobx_pkg::PC_W-1:0]    pc_ff;
   logic                         flush_ff;
   logic                         fileWe_ff;
   logic [bobx_pkg::DATA_W-1:0]  fileWd_ff;
   logic [bobx_pkg::FADDR_W-1:0] fileWa_ff;

   wire logic                         dest     = insnWord[bobx_pkg::DEST_BIT];
   wire logic [bobx_pkg::FADDR_W-1:0] fAddr    = insnWord[bobx_pkg::FADDR_W-1:0];
   wire logic [bobx_pkg::DATA_W-1:0]  literal  = insnWord[bobx_pkg::DATA_W-1:0];
   wire logic [bobx_pkg::JUMP_W-1:0]  jumpImm  = insnWord[bobx_pkg::JUMP_W-1:0];
   // Executing only when not inside the dead cycle of a skip or jump
   wire logic                         exec     = insnValid && !flush_ff;
   wire logic                         isDec    = (op == bobx_pkg::BOBX_OP_DEC_SKIP);
   wire logic                         isIncF   = (op == bobx_pkg::BOBX_OP_INC_FILE);
   wire logic                         isIncS   = (op == bobx_pkg::BOBX_OP_INC_SKIP);
   wire logic                         isOr     = (op == bobx_pkg::BOBX_OP_OR_LIT);
   wire logic                         isJump   = (op == bobx_pkg::BOBX_OP_JUMP);
   wire logic                         isFileOp = isDec || isIncF || isIncS;
   wire logic [bobx_pkg::DATA_W-1:0]  decRes   = fileRdData - bobx_pkg::ONE;
   wire logic [bobx_pkg::DATA_W-1:0]  incRes   = fileRdData + bobx_pkg::ONE;
   wire logic [bobx_pkg::DATA_W-1:0]  orRes    = acc_ff | literal;
   wire logic [bobx_pkg::DATA_W-1:0]  fileRes  = isDec ? decRes : incRes;
   wire logic                         resZero  = (fileRes == bobx_pkg::ZERO);
   // Skip only on a zero result; a nonzero result runs the next word
   wire logic                         doSkip   = exec && (isDec || isIncS) && resZero;
   wire logic [bobx_pkg::PC_W-1:0]    jumpPc   =
      {latchHigh[bobx_pkg::LATCH_HI:bobx_pkg::LATCH_LO], jumpImm};

   wire logic [bobx_pkg::DATA_W-1:0]  nxt_acc  =
      (exec && isOr) ? orRes :
      (exec && isFileOp && dest == bobx_pkg::DEST_ACC) ? fileRes :
      acc_ff;
   // Only the plain increment and the literal OR touch the zero flag
   wire logic                         nxt_zero =
      (exec && isIncF) ? (incRes == bobx_pkg::ZERO) :
      (exec && isOr)   ? (orRes == bobx_pkg::ZERO)  :
      zero_ff;
   wire logic [bobx_pkg::PC_W-1:0]    nxt_pc   =
      (exec && isJump) ? jumpPc :
      insnValid        ? pc_ff + 15'h0001 :
      pc_ff;
   wire logic                         nxt_flush = doSkip || (exec && isJump);
   wire logic                         nxt_fileWe =
      exec && isFileOp && dest == bobx_pkg::DEST_FILE;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         acc_ff  <= bobx_pkg::ACC_RST;
         zero_ff <= 1'b0;
         pc_ff   <= bobx_pkg::PC_RST;
      end else begin
         acc_ff  <= nxt_acc;
         zero_ff <= nxt_zero;
         pc_ff   <= nxt_pc;
      end
   end

   // Moves only on a presented word, so a dead cycle waits out idle gaps
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         flush_ff <= 1'b0;
      end else if (insnValid) begin
         flush_ff <= nxt_flush;
      end
   end

   // Write port registered so the file sees a clean one-cycle strobe
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         fileWe_ff <= 1'b0;
         fileWd_ff <= bobx_pkg::ZERO;
         fileWa_ff <= '0;
      end else begin
         fileWe_ff <= nxt_fileWe;
         fileWd_ff <= fileRes;
         fileWa_ff <= fAddr;
      end
   end

   always_comb begin
      fileRdAddr   = fAddr;
      fileWr.data  = fileWd_ff;
      fileWr.addr  = fileWa_ff;
      fileWr.wr    = fileWe_ff;
   end

   assign accOut   = acc_ff;
   assign zeroFlag = zero_ff;
   assign pcOut    = pc_ff;
   assign nopCycle = flush_ff;
   assign busy     = flush_ff;

   chk_dec_flags_kept: assert property (@(posedge clk_sys) disable iff (rst)
      (insnValid && !flush_ff && isDec) |=> $stable(zeroFlag))
      else $error("decrement-skip changed zero flag");
   chk_dec_skip_zero: assert property (@(posedge clk_sys) disable iff (rst)
      (insnValid && !flush_ff && isDec && fileRdData == 8'h01) |=> nopCycle)
      else $error("zero decrement did not skip");
   chk_jump_target: assert property (@(posedge clk_sys) disable iff (rst)
      (insnValid && !flush_ff && isJump) |=> pcOut[10:0] == $past(insnWord[10:0]))
      else $error("jump low bits wrong");
   chk_jump_high: assert property (@(posedge clk_sys) disable iff (rst)
      (insnValid && !flush_ff && isJump) |=> pcOut[14:11] == $past(latchHigh[6:3]))
      else $error("jump high bits wrong");
   chk_jump_two_cyc: assert property (@(posedge clk_sys) disable iff (rst)
      (insnValid && !flush_ff && isJump) ##1 insnValid |=> !nopCycle)
      else $error("jump not exactly two cycles");
   chk_inc_zero: assert property (@(posedge clk_sys) disable iff (rst)
      (insnValid && !flush_ff && isIncF) |=> zeroFlag == ($past(fileRdData) == 8'hFF))
      else $error("increment zero flag wrong");
   chk_incs_skip: assert property (@(posedge clk_sys) disable iff (rst)
      (insnValid && !flush_ff && isIncS) |=> nopCycle == ($past(fileRdData) == 8'hFF)
      && $stable(zeroFlag))
      else $error("increment-skip behaviour wrong");
   chk_or_result: assert property (@(posedge clk_sys) disable iff (rst)
      (insnValid && !flush_ff && isOr) |=> accOut == ($past(accOut) | $past(insnWord[7:0])))
      else $error("literal OR result wrong");
   chk_dest_file: assert property (@(posedge clk_sys) disable iff (rst)
      (insnValid && !flush_ff && isFileOp && insnWord[7]) |=> fileWr.wr && $stable(accOut))
      else $error("file destination not written");
   chk_noskip_one: assert property (@(posedge clk_sys) disable iff (rst)
      (insnValid && !flush_ff && isDec && fileRdData != 8'h01) |=> !nopCycle)
      else $error("nonzero skip result skipped");

   // Results are rebuilt from the sampled operands, not from internal sums
   chk_dest_acc: assert property (@(posedge clk_sys) disable iff (rst)
      (exec && isFileOp && dest == bobx_pkg::DEST_ACC)
      |=> !fileWr.wr)
      else $error("accumulator destination wrote file");
   chk_dec_value: assert property (@(posedge clk_sys) disable iff (rst)
      (exec && isDec && dest == bobx_pkg::DEST_ACC)
      |=> accOut == $past(fileRdData) - bobx_pkg::ONE)
      else $error("decrement-skip accumulator result wrong");
   chk_dec_wr_data: assert property (@(posedge clk_sys) disable iff (rst)
      (exec && isDec && dest == bobx_pkg::DEST_FILE)
      |=> fileWr.wr && fileWr.addr == $past(insnWord[bobx_pkg::FADDR_W-1:0])
      && fileWr.data == $past(fileRdData) - bobx_pkg::ONE)
      else $error("decrement-skip file write wrong");
   chk_nop_discard: assert property (@(posedge clk_sys) disable iff (rst)
      (insnValid && flush_ff)
      |=> $stable(accOut) && $stable(zeroFlag)
      && !fileWr.wr && !nopCycle)
      else $error("discarded word was executed");
   chk_nop_hold: assert property (@(posedge clk_sys) disable iff (rst)
      (!insnValid && nopCycle)
      |=> nopCycle)
      else $error("dead cycle lost while idle");
   chk_jump_flush: assert property (@(posedge clk_sys) disable iff (rst)
      (exec && isJump)
      |=> nopCycle && busy)
      else $error("jump did not take a dead cycle");
   chk_inc_value: assert property (@(posedge clk_sys) disable iff (rst)
      (exec && isIncF && dest == bobx_pkg::DEST_ACC)
      |=> accOut == $past(fileRdData) + bobx_pkg::ONE)
      else $error("increment accumulator result wrong");
   chk_incs_value: assert property (@(posedge clk_sys) disable iff (rst)
      (exec && isIncS && dest == bobx_pkg::DEST_FILE)
      |=> fileWr.wr && $stable(accOut)
      && fileWr.data == $past(fileRdData) + bobx_pkg::ONE)
      else $error("increment-skip file write wrong");
   chk_or_zero: assert property (@(posedge clk_sys) disable iff (rst)
      (exec && isOr)
      |=> zeroFlag == (accOut == bobx_pkg::ZERO) && !fileWr.wr)
      else $error("literal OR zero flag wrong");
   chk_incs_noskip: assert property (@(posedge clk_sys) disable iff (rst)
      (exec && isIncS && fileRdData != 8'hFF)
      |=> !nopCycle)
      else $error("nonzero increment-skip skipped");
   chk_pc_advance: assert property (@(posedge clk_sys) disable iff (rst)
      (insnValid && !(exec && isJump))
      |=> pcOut == $past(pcOut) + 15'h0001)
      else $error("program counter did not advance by one");
   chk_jump_state: assert property (@(posedge clk_sys) disable iff (rst)
      (exec && isJump)
      |=> $stable(accOut) && $stable(zeroFlag)
      && !fileWr.wr)
      else $error("jump changed data state");
   chk_inc_file_no_skip: assert property (@(posedge clk_sys) disable iff (rst)
      (exec && isIncF)
      |=> !nopCycle)
      else $error("plain increment skipped");
   chk_or_no_skip: assert property (@(posedge clk_sys) disable iff (rst)
      (exec && isOr)
      |=> !nopCycle)
      else $error("literal OR skipped");
endmodule

// file: testbench/test_byte_op_branch_exec.sv
/*
 Self-checking bench for the byte-op and branch execution unit.
 Assumes bobx_pkg is compiled first; the bench plays the file register read port.
*/
`timescale 1ns/1ps
module test_byte_op_branch_exec;
   logic                         clk_sys = 1'b0;
   logic                         rst = 1'b1;
   logic                         insnValid = 1'b0;
   logic [bobx_pkg::INSN_W-1:0]  insnWord = '0;
   logic [bobx_pkg::DATA_W-1:0]  fileRdData = '0;
   logic [bobx_pkg::LATCH_W-1:0] latchHigh = '0;
   logic [bobx_pkg::FADDR_W-1:0] fileRdAddr;
   bobx_pkg::bobx_file_wr_t      fileWr;
   logic [bobx_pkg::DATA_W-1:0]  accOut;
   logic                         zeroFlag;
   logic [bobx_pkg::PC_W-1:0]    pcOut;
   logic                         nopCycle;
   logic                         busy;
   logic [bobx_pkg::PC_W-1:0]    pcExp = '0;
   int                           fail_count = 0;
   int                           compares = 0;

   always #5 clk_sys = ~clk_sys;

   bobx_exec u_dut (.clk_sys(clk_sys), .rst(rst), .insnValid(insnValid), .insnWord(insnWord),
      .fileRdData(fileRdData), .latchHigh(latchHigh), .fileRdAddr(fileRdAddr), .fileWr(fileWr),
      .accOut(accOut), .zeroFlag(zeroFlag), .pcOut(pcOut), .nopCycle(nopCycle), .busy(busy));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   // Idle cycle between steps so a held word is never executed twice
   task automatic step(input logic [13:0] w, input logic [7:0] d);
      @(posedge clk_sys);
      insnValid  <= 1'b1;
      insnWord   <= w;
      fileRdData <= d;
      @(posedge clk_sys);
      insnValid  <= 1'b0;
      #1;
      pcExp = pcExp + 1'b1;
      check(fileRdAddr, w[6:0]);
   endtask

   task automatic expect_state(input logic [7:0] acc, input logic z, input logic nop);
      check(accOut, acc);
      check(zeroFlag, z);
      check(nopCycle, nop);
      check(busy, nop);
      check(pcOut, pcExp);
   endtask

   task automatic test_reset;
      expect_state(8'h00, 1'b0, 1'b0);
      check(fileWr.wr, 1'b0);
      $display("test_reset done");
   endtask

   task automatic test_or_literal;
      step({bobx_pkg::OPC_OR_LIT, 8'h00}, 8'h33);
      expect_state(8'h00, 1'b1, 1'b0);
      step({bobx_pkg::OPC_OR_LIT, 8'hA5}, 8'h00);
      expect_state(8'hA5, 1'b0, 1'b0);
      step({bobx_pkg::OPC_OR_LIT, 8'h5A}, 8'h00);
      expect_state(8'hFF, 1'b0, 1'b0);
      $display("test_or_literal done");
   endtask

   task automatic test_dec_skip;
      step({bobx_pkg::OPC_DEC_SKIP, 1'b1, 7'h03}, 8'h01);
      expect_state(8'hFF, 1'b0, 1'b1);
      check(fileWr, {8'h00, 7'h03, 1'b1});
      step({bobx_pkg::OPC_INC_FILE, 1'b0, 7'h04}, 8'h10);
      expect_state(8'hFF, 1'b0, 1'b0);
      step({bobx_pkg::OPC_DEC_SKIP, 1'b0, 7'h04}, 8'h03);
      expect_state(8'h02, 1'b0, 1'b0);
      check(fileWr.wr, 1'b0);
      $display("test_dec_skip done");
   endtask

   task automatic test_inc;
      step({bobx_pkg::OPC_INC_FILE, 1'b0, 7'h05}, 8'hFF);
      expect_state(8'h00, 1'b1, 1'b0);
      step({bobx_pkg::OPC_DEC_SKIP, 1'b1, 7'h05}, 8'h05);
      expect_state(8'h00, 1'b1, 1'b0);
      check(fileWr, {8'h04, 7'h05, 1'b1});
      step({bobx_pkg::OPC_INC_SKIP, 1'b1, 7'h05}, 8'h22);
      expect_state(8'h00, 1'b1, 1'b0);
      check(fileWr, {8'h23, 7'h05, 1'b1});
      step({bobx_pkg::OPC_INC_FILE, 1'b1, 7'h05}, 8'h7F);
      expect_state(8'h00, 1'b0, 1'b0);
      check(fileWr, {8'h80, 7'h05, 1'b1});
      $display("test_inc done");
   endtask

   task automatic test_inc_skip;
      step({bobx_pkg::OPC_INC_SKIP, 1'b0, 7'h06}, 8'hFF);
      expect_state(8'h00, 1'b0, 1'b1);
      step({bobx_pkg::OPC_INC_FILE, 1'b0, 7'h06}, 8'h10);
      expect_state(8'h00, 1'b0, 1'b0);
      step({bobx_pkg::OPC_INC_SKIP, 1'b1, 7'h07}, 8'h41);
      expect_state(8'h00, 1'b0, 1'b0);
      check(fileWr, {8'h42, 7'h07, 1'b1});
      $display("test_inc_skip done");
   endtask

   task automatic test_jump;
      @(posedge clk_sys);
      latchHigh <= 7'h5A;
      step({bobx_pkg::OPC_JUMP, 11'h2A5}, 8'h00);
      pcExp = {4'hB, 11'h2A5};
      expect_state(8'h00, 1'b0, 1'b1);
      step({bobx_pkg::OPC_INC_FILE, 1'b0, 7'h01}, 8'h10);
      expect_state(8'h00, 1'b0, 1'b0);
      $display("test_jump done");
   endtask

   task automatic stop_test;
      $display("Counts: %0d compares, %0d mismatches", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // About 40 cycles of tests; a wide margin still cuts a hang short
   initial begin
      repeat (2000) @(posedge clk_sys);
      fail_count++;
      stop_test();
   end

   initial begin
      repeat (6) @(posedge clk_sys);
      rst <= 1'b0;
      #1;
      test_reset();
      test_or_literal();
      test_dec_skip();
      test_inc();
      test_inc_skip();
      test_jump();
      stop_test();
   end
endmodule
